// [src/lrc_pkg.sv]
package lrc_pkg;

  // register byte addresses, one aligned 32-bit word each, except the label, which spans four words
  localparam logic [15:0] OFS_CONN_RESET = 16'h4000;
  localparam logic [15:0] OFS_PKT_LIMIT = 16'h400c;
  localparam logic [15:0] OFS_LINK_CFG = 16'h4014;
  localparam logic [15:0] OFS_LINK_DEF = 16'h4018;
  localparam logic [15:0] OFS_FAST_CAP = 16'h403c;
  localparam logic [15:0] OFS_STATUS = 16'h6000;
  localparam logic [15:0] OFS_IDLE_THR = 16'h6004;
  localparam logic [15:0] OFS_LABEL = 16'h6010;
  localparam int LABEL_WORDS = 4;

  // link_config layout: connection count in the upper half, rate code below
  localparam int CFG_RATE_LSB = 0;
  localparam int CFG_COUNT_LSB = 16;

  // status word fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_FAST_BIT = 1;
  localparam int STAT_FAST_DET_BIT = 2;
  localparam int STAT_DET_LSB = 16;
  localparam int MAX_CONN = 8;

  // fast_uplink_capability field
  localparam int CAP_PRESENT_BIT = 0;

  // reset values
  localparam logic [31:0] RST_LINK_DEF = 32'h0001_0001;
  localparam logic [31:0] RST_PKT_LIMIT = 32'h0000_0080;
  localparam logic [7:0] RST_IDLE_THR = 8'h08;

  // timing
  localparam longint unsigned CLK_HZ = 64'd10_000_000;
  localparam longint unsigned SETTLE_MS = 64'd200;
  localparam longint unsigned SETTLE_CYC = (SETTLE_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam int unsigned IDLE_CHECK_CYC = 32'd1000;

  typedef struct packed {
    logic [15:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
  } lrc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lrc_apb_rsp_t;

  typedef struct packed {
    logic [15:0] conn_count;
    logic [15:0] rate;
  } lrc_link_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_APPLY = 3'b010,
    ST_SETTLE = 3'b100
  } lrc_fsm_t;

  // byte-lane merge of an APB write into a stored word
  function automatic logic [31:0] lrc_merge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = wdata[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// [src/lrc_idle_watch.sv]
`timescale 1ns/100ps
module lrc_idle_watch #(
  parameter int LANES = 5,
  parameter int unsigned CHECK_CYC = lrc_pkg::IDLE_CHECK_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [LANES-1:0] idle_seen,
  input wire logic [7:0] threshold,
  output logic [LANES-1:0] rx_reset,
  output logic [LANES-1:0] lock_lost
);

  if (LANES < 1 || CHECK_CYC < 1 || CHECK_CYC > 65536) begin : g_chk
    $error("lrc_idle_watch: unsupported LANES or CHECK_CYC");
  end

  typedef struct packed {
    logic [15:0] tick;
    logic [LANES-1:0] seen;
    logic [LANES-1:0][7:0] miss;
    logic [LANES-1:0] tripped;
    logic [LANES-1:0] rx_reset;
    logic [LANES-1:0] lock_lost;
  } lrc_watch_t;

  lrc_watch_t st;
  lrc_watch_t next_st;
  logic window_end;

  assign window_end = (st.tick == 16'(CHECK_CYC - 1));

  always_comb begin
    next_st = st;
    next_st.rx_reset = '0;
    next_st.lock_lost = '0;
    next_st.seen = st.seen | idle_seen;
    next_st.tick = window_end ? 16'h0000 : 16'(st.tick + 16'h0001);
    if (window_end) begin
      next_st.seen = '0;
      for (int i = 0; i < LANES; i++) begin
        if (st.seen[i] || idle_seen[i]) begin
          next_st.miss[i] = 8'h00;
          next_st.tripped[i] = 1'b0;
        end else if (8'(st.miss[i] + 8'h01) >= threshold) begin
          next_st.miss[i] = 8'h00;
          next_st.rx_reset[i] = 1'b1;
          // a second trip with no idle in between means the reset did not help
          next_st.lock_lost[i] = st.tripped[i];
          next_st.tripped[i] = 1'b1;
        end else begin
          next_st.miss[i] = 8'(st.miss[i] + 8'h01);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rx_reset = st.rx_reset;
  assign lock_lost = st.lock_lost;

  missed_window_a: assert property (@(posedge clk) disable iff (!nrst)
    (window_end && !st.seen[LANES-1] && !idle_seen[LANES-1] && 8'(st.miss[LANES-1] + 8'h01) >= threshold)
    |=> rx_reset[LANES-1])
    else $error("idle loss did not reset the receiver");

  lost_needs_trip_a: assert property (@(posedge clk) disable iff (!nrst)
    lock_lost[LANES-1] |-> rx_reset[LANES-1] && $past(st.tripped[LANES-1]))
    else $error("lock loss raised without an earlier receiver reset");

endmodule

// [src/lrc_link_ctrl.sv]
`timescale 1ns/100ps
// Operation
// - all connections and the fast uplink share one rate setting
// - device answers the link_config write first, then switches every connection
// - device falls back to slow uplink if fast uplink undetected 200 ms after change
// - receivers watch idle words and reset after threshold consecutive misses
// - device returns uplink traffic to slow uplink when fast uplink lock is lost
// - string registers hold NUL-ended ASCII, no NUL when full width
// - accesses up to 104 bytes travel as one command message
// - larger accesses accepted as one or several aligned word messages
// - reads of lengths not a multiple of four bytes must work
// - registers sit on aligned words with big-endian byte order
// - bootstrap accesses get a final answer, never a wait answer
// - unused bootstrap register bits read zero
// - writable registers are readable too
// - all registers exist and take defaults after connection reset
module lrc_link_ctrl #(
  parameter int N_CONN = 4,
  parameter int unsigned SETTLE_CYCLES = 32'(lrc_pkg::SETTLE_CYC),
  parameter int unsigned CHECK_CYCLES = lrc_pkg::IDLE_CHECK_CYC,
  parameter logic [31:0] DEFAULT_LINK_CFG = lrc_pkg::RST_LINK_DEF,
  parameter logic [31:0] PKT_LIMIT = lrc_pkg::RST_PKT_LIMIT,
  parameter logic FAST_CAP = 1'b1
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire lrc_pkg::lrc_apb_req_t APB_REQ,
  output lrc_pkg::lrc_apb_rsp_t APB_RSP,
  input wire logic [N_CONN-1:0] CONN_DETECTED,
  input wire logic FAST_DETECTED,
  input wire logic [N_CONN:0] IDLE_SEEN,
  output lrc_pkg::lrc_link_cfg_t LINK_CFG,
  output logic RATE_APPLY,
  output logic UPLINK_FAST,
  output logic [N_CONN:0] RX_RESET
);

  if (N_CONN < 1 || N_CONN > lrc_pkg::MAX_CONN || SETTLE_CYCLES < 1 || CHECK_CYCLES < 1) begin : g_chk
    $error("lrc_link_ctrl: unsupported parameter value");
  end

  typedef struct packed {
    lrc_pkg::lrc_fsm_t fsm;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [31:0] link_cfg;
    lrc_pkg::lrc_link_cfg_t applied;
    logic apply;
    logic uplink_fast;
    logic [31:0] cnt;
    logic [7:0] thr;
    logic [lrc_pkg::LABEL_WORDS-1:0][31:0] label;
    logic [N_CONN-1:0] det_meta;
    logic [N_CONN-1:0] det_sync;
    logic fast_meta;
    logic fast_sync;
    logic fast_prev;
  } lrc_state_t;

  localparam lrc_state_t RST_STATE = '{
    fsm: lrc_pkg::ST_IDLE,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000,
    link_cfg: DEFAULT_LINK_CFG,
    applied: lrc_pkg::lrc_link_cfg_t'(DEFAULT_LINK_CFG),
    apply: 1'b0,
    uplink_fast: 1'b0,
    cnt: 32'h0000_0000,
    thr: lrc_pkg::RST_IDLE_THR,
    label: '0,
    det_meta: '0,
    det_sync: '0,
    fast_meta: 1'b0,
    fast_sync: 1'b0,
    fast_prev: 1'b0
  };

  lrc_state_t st;
  lrc_state_t next_st;
  logic [N_CONN:0] rx_reset;
  logic [N_CONN:0] lock_lost;
  logic setup;
  logic accept_wr;
  logic hit;
  logic [31:0] rd_word;
  logic settle_end;

  assign setup = APB_REQ.psel && !APB_REQ.penable;
  assign accept_wr = APB_REQ.psel && APB_REQ.penable && st.pready && APB_REQ.pwrite;
  assign settle_end = (st.cnt == 32'(SETTLE_CYCLES - 1));

  // index N_CONN is the fast uplink receiver
  lrc_idle_watch #(
    .LANES(N_CONN + 1),
    .CHECK_CYC(CHECK_CYCLES)
  ) u_watch (
    .clk(CLK),
    .nrst(NRST),
    .idle_seen(IDLE_SEEN),
    .threshold(st.thr),
    .rx_reset(rx_reset),
    .lock_lost(lock_lost)
  );

  // read decode; reads have no side effects, so a host may take fewer bytes than a word
  always_comb begin
    rd_word = 32'h0000_0000;
    hit = 1'b1;
    if (APB_REQ.paddr[1:0] != 2'b00) begin
      hit = 1'b0;
    end else if (APB_REQ.paddr[15:4] == lrc_pkg::OFS_LABEL[15:4]) begin
      rd_word = st.label[APB_REQ.paddr[3:2]];
    end else begin
      case (APB_REQ.paddr)
        lrc_pkg::OFS_CONN_RESET: rd_word = 32'h0000_0000;
        lrc_pkg::OFS_PKT_LIMIT: rd_word = PKT_LIMIT;
        lrc_pkg::OFS_LINK_CFG: rd_word = st.link_cfg;
        lrc_pkg::OFS_LINK_DEF: rd_word = DEFAULT_LINK_CFG;
        lrc_pkg::OFS_FAST_CAP: rd_word[lrc_pkg::CAP_PRESENT_BIT] = FAST_CAP;
        lrc_pkg::OFS_STATUS: begin
          rd_word[lrc_pkg::STAT_BUSY_BIT] = (st.fsm != lrc_pkg::ST_IDLE);
          rd_word[lrc_pkg::STAT_FAST_BIT] = st.uplink_fast;
          rd_word[lrc_pkg::STAT_FAST_DET_BIT] = st.fast_sync;
          rd_word[lrc_pkg::STAT_DET_LSB +: N_CONN] = st.det_sync;
        end
        lrc_pkg::OFS_IDLE_THR: rd_word[7:0] = st.thr;
        default: hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    next_st = st;
    next_st.apply = 1'b0;
    next_st.pready = 1'b0;
    next_st.pslverr = 1'b0;
    // read data stands only with pready, zero otherwise
    next_st.prdata = 32'h0000_0000;
    next_st.det_meta = CONN_DETECTED;
    next_st.det_sync = st.det_meta;
    next_st.fast_meta = FAST_DETECTED;
    next_st.fast_sync = st.fast_meta;
    next_st.fast_prev = st.fast_sync;

    // every access ends in the cycle after setup, never stretched
    if (setup) begin
      next_st.pready = 1'b1;
      next_st.pslverr = !hit;
      next_st.prdata = APB_REQ.pwrite ? 32'h0000_0000 : rd_word;
    end

    case (st.fsm)
      lrc_pkg::ST_IDLE: begin
        if (FAST_CAP && st.fast_sync && !st.fast_prev && !st.uplink_fast) begin
          next_st.uplink_fast = 1'b1;
        end
      end
      lrc_pkg::ST_APPLY: begin
        // one setting drives every connection and the fast uplink alike
        next_st.applied = lrc_pkg::lrc_link_cfg_t'(st.link_cfg);
        next_st.apply = 1'b1;
        next_st.cnt = 32'h0000_0000;
        next_st.fsm = st.uplink_fast ? lrc_pkg::ST_SETTLE : lrc_pkg::ST_IDLE;
      end
      lrc_pkg::ST_SETTLE: begin
        next_st.cnt = st.cnt + 32'h0000_0001;
        if (settle_end) begin
          if (!st.fast_sync) begin
            next_st.uplink_fast = 1'b0;
          end
          next_st.fsm = lrc_pkg::ST_IDLE;
        end
      end
      default: next_st.fsm = lrc_pkg::ST_IDLE;
    endcase

    if (lock_lost[N_CONN] && st.uplink_fast) begin
      next_st.uplink_fast = 1'b0;
    end

    // writes land only at the acknowledging edge, so the switch follows the answer
    if (accept_wr && st.pslverr == 1'b0) begin
      if (APB_REQ.paddr[15:4] == lrc_pkg::OFS_LABEL[15:4] && APB_REQ.paddr[1:0] == 2'b00) begin
        next_st.label[APB_REQ.paddr[3:2]] =
          lrc_pkg::lrc_merge(st.label[APB_REQ.paddr[3:2]], APB_REQ.pwdata, APB_REQ.pstrb);
      end else begin
        case (APB_REQ.paddr)
          lrc_pkg::OFS_LINK_CFG: begin
            next_st.link_cfg = lrc_pkg::lrc_merge(st.link_cfg, APB_REQ.pwdata, APB_REQ.pstrb);
            next_st.fsm = lrc_pkg::ST_APPLY;
          end
          lrc_pkg::OFS_IDLE_THR: begin
            next_st.thr = 8'(lrc_pkg::lrc_merge({24'h000000, st.thr}, APB_REQ.pwdata, APB_REQ.pstrb));
          end
          lrc_pkg::OFS_CONN_RESET: begin
            // back to defaults; the rate is re-applied so the phys follow
            next_st = RST_STATE;
            // the setting in force moves only with its apply pulse
            next_st.applied = st.applied;
            next_st.fsm = lrc_pkg::ST_APPLY;
          end
          default: next_st.fsm = next_st.fsm;
        endcase
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st <= RST_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign APB_RSP = '{prdata: st.prdata, pready: st.pready, pslverr: st.pslverr};
  assign LINK_CFG = st.applied;
  assign RATE_APPLY = st.apply;
  assign UPLINK_FAST = st.uplink_fast;
  assign RX_RESET = rx_reset;

  no_wait_ack_a: assert property (@(posedge CLK) disable iff (!NRST)
    (APB_REQ.psel && !APB_REQ.penable) |=> APB_RSP.pready ##1 !APB_RSP.pready)
    else $error("access was not answered in one cycle");

  cap_unused_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && !APB_REQ.pwrite && APB_REQ.paddr == lrc_pkg::OFS_FAST_CAP)
    |=> APB_RSP.prdata == {31'h0000_0000, FAST_CAP})
    else $error("capability word has nonzero unused bits");

  cfg_readback_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && !APB_REQ.pwrite && APB_REQ.paddr == lrc_pkg::OFS_LINK_CFG)
    |=> APB_RSP.prdata == $past(st.link_cfg))
    else $error("link_config read back wrong value");

  apply_after_ack_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr == lrc_pkg::OFS_LINK_CFG)
    |=> !RATE_APPLY ##1 RATE_APPLY && LINK_CFG == lrc_pkg::lrc_link_cfg_t'($past(st.link_cfg)))
    else $error("rate not applied two cycles after the acknowledged write");

  cfg_only_on_apply_a: assert property (@(posedge CLK) disable iff (!NRST)
    !$stable(LINK_CFG) |-> RATE_APPLY)
    else $error("link setting changed without an apply pulse");

  settle_fallback_a: assert property (@(posedge CLK) disable iff (!NRST)
    (st.fsm == lrc_pkg::ST_SETTLE && settle_end && !st.fast_sync) |=> !UPLINK_FAST)
    else $error("fast uplink kept after failed settle");

  lock_fallback_a: assert property (@(posedge CLK) disable iff (!NRST)
    (lock_lost[N_CONN] && UPLINK_FAST) |=> !UPLINK_FAST)
    else $error("fast uplink kept after lock loss");

  reset_default_a: assert property (@(posedge CLK)
    !NRST |=> LINK_CFG == lrc_pkg::lrc_link_cfg_t'(DEFAULT_LINK_CFG) && !UPLINK_FAST && !APB_RSP.pready)
    else $error("reset did not restore defaults");

  unmapped_err_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && APB_REQ.paddr[1:0] != 2'b00) |=> APB_RSP.pslverr && APB_RSP.prdata == 32'h0000_0000)
    else $error("misaligned access not refused");

  apply_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
    RATE_APPLY |=> !RATE_APPLY)
    else $error("apply pulse longer than one cycle");

  ready_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
    APB_RSP.pready |=> !APB_RSP.pready)
    else $error("ready held longer than one cycle");

  idle_bus_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
    !APB_RSP.pready |-> APB_RSP.prdata == 32'h0000_0000 && !APB_RSP.pslverr)
    else $error("response bits set outside an answer");

  ready_after_setup_a: assert property (@(posedge CLK) disable iff (!NRST)
    APB_RSP.pready |-> $past(setup))
    else $error("ready without a setup cycle");

  unmapped_refused_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && !hit) |=> APB_RSP.pslverr && APB_RSP.prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  mapped_accepted_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && hit) |=> !APB_RSP.pslverr)
    else $error("mapped access refused");

  write_data_zero_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && APB_REQ.pwrite) |=> APB_RSP.prdata == 32'h0000_0000)
    else $error("write answered with read data");

  fast_enable_a: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(UPLINK_FAST) |-> FAST_CAP && $past(st.fsm) == lrc_pkg::ST_IDLE && $past(st.fast_sync))
    else $error("fast uplink taken without detection");

  settle_keep_a: assert property (@(posedge CLK) disable iff (!NRST)
    (st.fsm == lrc_pkg::ST_SETTLE && settle_end && st.fast_sync && UPLINK_FAST
     && !lock_lost[N_CONN] && !accept_wr) |=> UPLINK_FAST)
    else $error("fast uplink dropped although detected");

  apply_value_a: assert property (@(posedge CLK) disable iff (!NRST)
    RATE_APPLY |-> LINK_CFG == lrc_pkg::lrc_link_cfg_t'($past(st.link_cfg)))
    else $error("applied setting differs from link_config");

  settle_entry_a: assert property (@(posedge CLK) disable iff (!NRST)
    RATE_APPLY |-> (st.fsm == lrc_pkg::ST_SETTLE) == $past(UPLINK_FAST))
    else $error("settle window not tied to fast uplink use");

  thr_write_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr == lrc_pkg::OFS_IDLE_THR && APB_REQ.pstrb[0])
    |=> st.thr == $past(APB_REQ.pwdata[7:0]))
    else $error("idle threshold write lost");

  conn_reset_apply_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr == lrc_pkg::OFS_CONN_RESET)
    |=> !UPLINK_FAST ##1 RATE_APPLY && LINK_CFG == lrc_pkg::lrc_link_cfg_t'(DEFAULT_LINK_CFG))
    else $error("connection reset did not re-apply the default");

  conn_reset_regs_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr == lrc_pkg::OFS_CONN_RESET)
    |=> st.label == '0 && st.thr == lrc_pkg::RST_IDLE_THR && st.link_cfg == DEFAULT_LINK_CFG)
    else $error("connection reset left registers changed");

  label_write_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr[15:4] == lrc_pkg::OFS_LABEL[15:4] && APB_REQ.pstrb == 4'hf)
    |=> st.label[$past(APB_REQ.paddr[3:2])] == $past(APB_REQ.pwdata))
    else $error("label word write lost");

  cfg_write_a: assert property (@(posedge CLK) disable iff (!NRST)
    (accept_wr && !st.pslverr && APB_REQ.paddr == lrc_pkg::OFS_LINK_CFG && APB_REQ.pstrb == 4'hf)
    |=> st.link_cfg == $past(APB_REQ.pwdata))
    else $error("link_config write lost");

  status_unused_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && !APB_REQ.pwrite && APB_REQ.paddr == lrc_pkg::OFS_STATUS)
    |=> APB_RSP.prdata[15:3] == 13'h0000 && APB_RSP.prdata[lrc_pkg::STAT_DET_LSB +: N_CONN] == $past(st.det_sync))
    else $error("status word wrong or unused bits set");

  thr_read_a: assert property (@(posedge CLK) disable iff (!NRST)
    (setup && !APB_REQ.pwrite && APB_REQ.paddr == lrc_pkg::OFS_IDLE_THR)
    |=> APB_RSP.prdata == {24'h000000, $past(st.thr)})
    else $error("idle threshold read back wrong value");

endmodule

// [sim/lrc_host_model.sv]
`timescale 1ns/100ps
module lrc_host_model #(
  parameter int N = 4,
  // retune time kept as a parameter so integrators can tune it
  parameter logic [3:0] RELOCK = 4'h6
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rate_apply,
  input wire logic fast_ok,
  input wire logic [N:0] idle_mask,
  output logic [N-1:0] conn_detected,
  output logic fast_detected,
  output logic [N:0] idle_seen
);
  logic [3:0] relock = 4'h0;
  logic tick = 1'b0;
  // host follows every rate change, so all lanes lose lock while it retunes
  always_ff @(posedge clk) begin
    if (!nrst) begin
      relock <= 4'h0;
      tick <= 1'b0;
    end else begin
      tick <= ~tick;
      if (rate_apply) begin
        relock <= RELOCK;
      end else if (relock != 4'h0) begin
        relock <= relock - 4'h1;
      end
    end
  end
  // lanes come back after the wait; fast lane only when the test lets it lock
  assign conn_detected = (nrst && relock == 4'h0) ? {N{1'b1}} : '0;
  assign fast_detected = nrst && fast_ok && relock == 4'h0;
  // idle words every other cycle on live lanes; a cleared mask bit starves a receiver
  assign idle_seen = (tick && relock == 4'h0) ? idle_mask : '0;
endmodule

// [sim/lrc_link_ctrl_test.sv]
`timescale 1ns/100ps
module lrc_link_ctrl_test;
  localparam int N = 4;
  // settle window shortened so the run stays short
  localparam int S = 50;
  logic clk;
  logic nrst;
  logic fast_ok;
  logic rate_apply;
  logic uplink_fast;
  logic fast_det;
  logic [N-1:0] conn_det;
  logic [N:0] idle_mask;
  logic [N:0] idle_seen;
  logic [N:0] rx_reset;
  lrc_pkg::lrc_apb_req_t req;
  lrc_pkg::lrc_apb_rsp_t rsp;
  lrc_pkg::lrc_link_cfg_t link_cfg;
  int n_fail;
  int n_tests;
  int cnt;
  logic [31:0] rd;
  logic err;

  lrc_link_ctrl #(.N_CONN(N), .SETTLE_CYCLES(S), .CHECK_CYCLES(4)) dut_u (
    .CLK(clk), .NRST(nrst), .APB_REQ(req), .APB_RSP(rsp), .CONN_DETECTED(conn_det),
    .FAST_DETECTED(fast_det), .IDLE_SEEN(idle_seen), .LINK_CFG(link_cfg),
    .RATE_APPLY(rate_apply), .UPLINK_FAST(uplink_fast), .RX_RESET(rx_reset));

  lrc_host_model #(.N(N)) host_u (
    .clk(clk), .nrst(nrst), .rate_apply(rate_apply), .fast_ok(fast_ok), .idle_mask(idle_mask),
    .conn_detected(conn_det), .fast_detected(fast_det), .idle_seen(idle_seen));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // master holds the request until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d, pstrb: s};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    chk(32'(n), 32'h1);
    if (n >= 20) begin
      report_and_stop();
    end
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic e);
    apb(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, e});
  endtask

  // bounded wait: 0 apply pulse, 1 fast up, 2 fast down, 3 fast lane receiver reset
  task automatic wait_ev(input int sel, input int lim, output int n);
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < lim) begin
      @(posedge clk);
      n++;
      case (sel)
        0: hit = (rate_apply === 1'b1);
        1: hit = (uplink_fast === 1'b1);
        2: hit = (uplink_fast === 1'b0);
        default: hit = (rx_reset[N] === 1'b1);
      endcase
    end
    chk({31'h0, hit}, 32'h1);
    if (!hit) begin
      report_and_stop();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    nrst = 1'b0;
    fast_ok = 1'b0;
    idle_mask = '1;
    req = '0;
    n_fail = 0;
    n_tests = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(lrc_pkg::OFS_LINK_DEF, lrc_pkg::RST_LINK_DEF, 1'b0);
    rd_chk(lrc_pkg::OFS_LINK_CFG, lrc_pkg::RST_LINK_DEF, 1'b0);
    rd_chk(lrc_pkg::OFS_PKT_LIMIT, lrc_pkg::RST_PKT_LIMIT, 1'b0);
    rd_chk(lrc_pkg::OFS_FAST_CAP, 32'h1, 1'b0);
    rd_chk(lrc_pkg::OFS_IDLE_THR, 32'h8, 1'b0);
    rd_chk(lrc_pkg::OFS_STATUS, 32'h000f_0000, 1'b0);
    rd_chk(16'h4004, 32'h0, 1'b1);
    rd_chk(16'h4016, 32'h0, 1'b1);
    $display("defaults test done");
    // full-width label carries no terminator, so all sixteen bytes must survive
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, lrc_pkg::OFS_LABEL + 16'(4 * i), 32'h4142_4340 + 32'(i), 4'hf);
    end
    for (int i = 0; i < 4; i++) begin
      rd_chk(lrc_pkg::OFS_LABEL + 16'(4 * i), 32'h4142_4340 + 32'(i), 1'b0);
    end
    apb(1'b1, lrc_pkg::OFS_IDLE_THR, 32'hffff_ff03, 4'h1);
    rd_chk(lrc_pkg::OFS_IDLE_THR, 32'h3, 1'b0);
    $display("register test done");
    fast_ok <= 1'b1;
    wait_ev(1, 20, cnt);
    rd_chk(lrc_pkg::OFS_STATUS, 32'h000f_0006, 1'b0);
    fast_ok <= 1'b0;
    apb(1'b1, lrc_pkg::OFS_LINK_CFG, 32'h0004_0028, 4'hf);
    @(posedge clk);
    chk({31'h0, rate_apply}, 32'h0);
    @(posedge clk);
    chk({31'h0, rate_apply}, 32'h1);
    chk(link_cfg, 32'h0004_0028);
    wait_ev(2, S + 10, cnt);
    chk(32'(cnt >= S - 1 && cnt <= S + 2), 32'h1);
    fast_ok <= 1'b1;
    wait_ev(1, 20, cnt);
    apb(1'b1, lrc_pkg::OFS_LINK_CFG, 32'h0001_0001, 4'hf);
    repeat (S + 10) @(posedge clk);
    chk({31'h0, uplink_fast}, 32'h1);
    chk(link_cfg, 32'h0001_0001);
    $display("rate change test done");
    // starve only the fast lane: first trip resets its receiver, second drops it
    idle_mask <= 5'b01111;
    wait_ev(3, 40, cnt);
    chk({28'h0, rx_reset[N-1:0]}, 32'h0);
    wait_ev(2, 40, cnt);
    idle_mask <= '1;
    $display("idle loss test done");
    apb(1'b1, lrc_pkg::OFS_CONN_RESET, 32'hffff_ffff, 4'hf);
    wait_ev(0, 4, cnt);
    chk(link_cfg, lrc_pkg::RST_LINK_DEF);
    rd_chk(lrc_pkg::OFS_IDLE_THR, 32'h8, 1'b0);
    rd_chk(lrc_pkg::OFS_LABEL, 32'h0, 1'b0);
    rd_chk(lrc_pkg::OFS_CONN_RESET, 32'h0, 1'b0);
    $display("connection reset test done");
    report_and_stop();
  end
endmodule
